//--- picc_pkg.sv
// Constants and types shared by the pixel input capture control block.
// Assumes a single 100 MHz clock; all pins are synchronous to it.
package picc_pkg;

	// =========================================================================
	// Pixel bus and buffering
	localparam int PIX_WIDTH  = 24;                    // Full pixel word
	localparam int HALF_WIDTH = 12;                    // Half word on narrow bus
	localparam int FIFO_DEPTH = 8;                     // Words in the capture buffer

	// =========================================================================
	// Two-wire programming port
	localparam logic [6:0] I2C_DEV_ADDR = 7'h38;       // Slave address
	localparam int         I2C_MAX_KHZ  = 100;         // Host clock ceiling
	localparam logic [7:0] REG_STATUS   = 8'h00;       // Status, write one to clear
	localparam logic [7:0] REG_CONTROL  = 8'h01;       // Control byte
	localparam int         ST_DETECT    = 0;           // Status: display attached
	localparam int         ST_CHANGE    = 1;           // Status: detection changed
	localparam int         ST_OVERFLOW  = 2;           // Status: pixel word dropped
	localparam int         ST_PWR_DOWN  = 3;           // Status: serial outputs off
	localparam int         CT_SOFT_PD   = 0;           // Control: soft power-down
	localparam logic [7:0] CONTROL_RST  = 8'h00;       // Control reset value

	// =========================================================================
	// Programming port states, Gray along the usual path
	typedef enum logic [2:0] {
		I2C_IDLE     = 3'h0,
		I2C_ADDR     = 3'h1,
		I2C_ADDR_ACK = 3'h3,
		I2C_RX       = 3'h2,
		I2C_RX_ACK   = 3'h6,
		I2C_TX       = 3'h7,
		I2C_TX_ACK   = 3'h5
	} picc_i2c_st_t;

endpackage : picc_pkg

//--- picc_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module picc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 count;
	} picc_fifo_st_t;

	picc_fifo_st_t s_q;
	picc_fifo_st_t s_d;
	logic          push;
	logic          pop;

	// =========================================================================
	// Flags and storage
	assign in_ready  = (s_q.count != DEPTH[AW:0]);
	assign out_valid = (s_q.count != '0);
	assign out_data  = s_q.mem[s_q.rd];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Next state of pointers and entries
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr          = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
		end
		s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : picc_fifo
`default_nettype wire

//--- picc_top.sv
// Input-side control of a display transmitter: pixel capture, display
// detection, power-down and the two-wire programming slave.
// Assumes all pins are synchronous to CLOCK (100 MHz) and sampled each cycle.
//
// Overview of operation
// - Two-wire programming slave; host keeps its clock at or below 100 kHz.
// - Display detected from hot-plug pin or internal receiver sense, as selected.
// - Monitor sense shows detection state or a change-of-state flag, as configured.
// - Pixel bus accepted as 12-bit halves or 24-bit words per bus width select.
// - Data latched on one edge or both edges per dual latch select.
// - Single-edge mode latches on rising or falling edge per polarity select.
// - Power-down low enters power-down and disables serial outputs.
// - Reset-select low returns configuration and engine state to reset.
// - Single edge: polarity 0 latches falling edge, 1 latches rising edge.
// - Dual edge on 12-bit bus captures falling then rising edge.
`timescale 1ns/1ps
`default_nettype none
module picc_top (
	// Clock and reset
	input  wire logic                          CLOCK,
	input  wire logic                          RST,
	input  wire logic                          RESET_SELECT_N,
	// Configuration pins
	input  wire logic                          BUS_WIDTH_SELECT,
	input  wire logic                          DUAL_LATCH_SELECT,
	input  wire logic                          EDGE_SELECT,
	input  wire logic                          DETECT_SOURCE,
	input  wire logic                          SENSE_MODE,
	input  wire logic                          POWER_DOWN_N,
	// Pixel bus from the controller
	input  wire logic                          PIXEL_INPUT_CLOCK,
	input  wire logic                          PIXEL_INPUT_CLOCK_N,
	input  wire logic [picc_pkg::PIX_WIDTH-1:0] PIXEL_DATA,
	// Captured pixel stream
	output logic                               PIXEL_OUT_VALID,
	input  wire logic                          PIXEL_OUT_READY,
	output logic [picc_pkg::PIX_WIDTH-1:0]     PIXEL_OUT_DATA,
	output logic                               CAPTURE_STALL,
	// Detection
	input  wire logic                          HOT_PLUG_INPUT,
	input  wire logic                          RX_SENSE,
	output logic                               MONITOR_SENSE_OUTPUT,
	// Serial output control
	output logic                               SERIAL_OUT_EN,
	// Two-wire programming port
	input  wire logic                          SCL_IN,
	input  wire logic                          SDA_IN,
	output logic                               SDA_OUT,
	output logic                               SDA_OE
);
	import picc_pkg::*;

	typedef struct packed {
		logic                  pclk;        // Previous clock samples
		logic                  nclk;
		logic [HALF_WIDTH-1:0] half;        // First half of a narrow word
		logic                  half_v;
		logic                  overflow;
		logic                  detect;
		logic                  change;
		logic                  mon;
		logic                  ser_en;
		logic                  stall;
		logic [7:0]            control;
		picc_i2c_st_t          st;
		logic                  scl;
		logic                  sda;
		logic [3:0]            bits;
		logic [7:0]            shift;
		logic                  rw;
		logic                  first;       // Next written byte is the pointer
		logic [7:0]            ptr;
		logic                  drv;         // Ack phase in progress
		logic                  nack;
		logic                  oe;
	} picc_st_t;

	picc_st_t              s_q;
	picc_st_t              s_d;
	logic                  rst_any;
	logic                  p_rise;
	logic                  p_fall;
	logic                  n_rise;
	logic                  n_fall;
	logic                  p_sel;
	logic                  n_sel;
	logic                  word_v;
	logic [PIX_WIDTH-1:0]  word;
	logic                  fifo_ready;
	logic                  pd_active;
	logic                  det_now;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  i2c_start;
	logic                  i2c_stop;
	logic [7:0]            rd_byte;
	logic [7:0]            rx_byte;

	// =========================================================================
	// Reset and power-down
	assign rst_any   = RST | ~RESET_SELECT_N;
	assign pd_active = ~POWER_DOWN_N | s_q.control[CT_SOFT_PD];

	// =========================================================================
	// Pixel clock edges, clocks sampled as ordinary inputs
	assign p_rise = PIXEL_INPUT_CLOCK & ~s_q.pclk;
	assign p_fall = ~PIXEL_INPUT_CLOCK & s_q.pclk;
	assign n_rise = PIXEL_INPUT_CLOCK_N & ~s_q.nclk;
	assign n_fall = ~PIXEL_INPUT_CLOCK_N & s_q.nclk;
	assign p_sel  = EDGE_SELECT ? p_rise : p_fall;
	assign n_sel  = EDGE_SELECT ? n_rise : n_fall;

	// Word assembly per bus width and latch mode
	always_comb begin
		word_v = 1'b0;
		word   = PIXEL_DATA;
		if (BUS_WIDTH_SELECT) begin
			// Full word each chosen edge, or on both edges
			word_v = DUAL_LATCH_SELECT ? (p_rise | p_fall) : p_sel;
		end else if (DUAL_LATCH_SELECT) begin
			// One clock, falling half then rising half
			word_v = p_rise & s_q.half_v;
			word   = {PIXEL_DATA[HALF_WIDTH-1:0], s_q.half};
		end else begin
			// Two clocks, first half on one, second on the other
			word_v = n_sel & s_q.half_v;
			word   = {PIXEL_DATA[HALF_WIDTH-1:0], s_q.half};
		end
	end

	assign det_now = DETECT_SOURCE ? RX_SENSE : HOT_PLUG_INPUT;

	// =========================================================================
	// Two-wire bus conditions
	assign scl_rise  = SCL_IN & ~s_q.scl;
	assign scl_fall  = ~SCL_IN & s_q.scl;
	assign i2c_start = SCL_IN & s_q.scl & s_q.sda & ~SDA_IN;
	assign i2c_stop  = SCL_IN & s_q.scl & ~s_q.sda & SDA_IN;
	assign rx_byte   = {s_q.shift[6:0], SDA_IN};

	// Read data for the current pointer
	always_comb begin
		rd_byte = 8'h00;
		if (s_q.ptr == REG_STATUS) begin
			rd_byte[ST_DETECT]   = s_q.detect;
			rd_byte[ST_CHANGE]   = s_q.change;
			rd_byte[ST_OVERFLOW] = s_q.overflow;
			rd_byte[ST_PWR_DOWN] = ~s_q.ser_en;
		end else if (s_q.ptr == REG_CONTROL) begin
			rd_byte = s_q.control;
		end
	end

	// =========================================================================
	// Next state
	always_comb begin
		s_d      = s_q;
		s_d.pclk = PIXEL_INPUT_CLOCK;
		s_d.nclk = PIXEL_INPUT_CLOCK_N;
		s_d.scl  = SCL_IN;
		s_d.sda  = SDA_IN;

		// First half capture on the narrow bus
		if (!BUS_WIDTH_SELECT) begin
			if (DUAL_LATCH_SELECT ? p_fall : p_sel) begin
				s_d.half   = PIXEL_DATA[HALF_WIDTH-1:0];
				s_d.half_v = 1'b1;
			end else if (word_v) begin
				s_d.half_v = 1'b0;
			end
		end else begin
			s_d.half_v = 1'b0;
		end

		// Detection level, serial enable and stall
		s_d.detect = det_now;
		s_d.ser_en = ~pd_active;
		s_d.stall  = ~fifo_ready;

		// Software clears of sticky flags; hardware sets win
		if (s_q.st == I2C_RX && scl_rise && s_q.bits == 4'd7 && !s_q.first) begin
			if (s_q.ptr == REG_STATUS) begin
				if (rx_byte[ST_CHANGE]) s_d.change = 1'b0;
				if (rx_byte[ST_OVERFLOW]) s_d.overflow = 1'b0;
			end else if (s_q.ptr == REG_CONTROL) begin
				s_d.control = rx_byte;
			end
		end
		if (det_now != s_q.detect) s_d.change = 1'b1;
		if (word_v && !pd_active && !fifo_ready) s_d.overflow = 1'b1;
		s_d.mon  = SENSE_MODE ? s_d.change : det_now;

		// Programming slave
		unique case (s_q.st)
			I2C_IDLE: begin
				s_d.oe = 1'b0;
			end
			I2C_ADDR: begin
				if (scl_rise) begin
					s_d.shift = rx_byte;
					s_d.bits  = s_q.bits + 4'd1;
					if (s_q.bits == 4'd7) begin
						s_d.rw   = SDA_IN;
						s_d.bits = 4'd0;
						s_d.st   = (s_q.shift[6:0] == I2C_DEV_ADDR) ? I2C_ADDR_ACK : I2C_IDLE;
					end
				end
			end
			I2C_ADDR_ACK, I2C_RX_ACK: begin
				if (scl_fall) begin
					s_d.drv = ~s_q.drv;
					s_d.oe  = ~s_q.drv;                         // Ack low
					if (s_q.drv) begin
						s_d.bits = 4'd0;
						if (s_q.st == I2C_ADDR_ACK && s_q.rw) begin
							s_d.st    = I2C_TX;
							s_d.shift = rd_byte;
							s_d.oe    = ~rd_byte[7];
						end else begin
							s_d.st = I2C_RX;
						end
					end
				end
			end
			I2C_RX: begin
				if (scl_rise) begin
					s_d.shift = rx_byte;
					s_d.bits  = s_q.bits + 4'd1;
					if (s_q.bits == 4'd7) begin
						s_d.st    = I2C_RX_ACK;
						s_d.first = 1'b0;
						s_d.ptr   = s_q.first ? rx_byte : s_q.ptr + 8'd1;
					end
				end
			end
			I2C_TX: begin
				if (scl_rise) begin
					s_d.bits = s_q.bits + 4'd1;
				end else if (scl_fall) begin
					if (s_q.bits == 4'd8) begin
						s_d.oe = 1'b0;
						s_d.st = I2C_TX_ACK;
					end else begin
						s_d.shift = {s_q.shift[6:0], 1'b0};
						s_d.oe    = ~s_q.shift[6];
					end
				end
			end
			I2C_TX_ACK: begin
				if (scl_rise) begin
					s_d.nack = SDA_IN;
				end else if (scl_fall) begin
					if (s_q.nack) begin
						s_d.st = I2C_IDLE;
					end else begin
						s_d.ptr   = s_q.ptr + 8'd1;
						s_d.st    = I2C_TX;
						s_d.bits  = 4'd0;
						s_d.shift = (s_q.ptr + 8'd1 == REG_CONTROL) ? s_q.control : 8'h00;
						s_d.oe    = (s_q.ptr + 8'd1 == REG_CONTROL) ? ~s_q.control[7] : 1'b1;
					end
				end
			end
			default: begin
				s_d.st = I2C_IDLE;
			end
		endcase

		// Start and stop override any state
		if (i2c_start) begin
			s_d.st    = I2C_ADDR;
			s_d.bits  = 4'd0;
			s_d.first = 1'b1;
			s_d.drv   = 1'b0;
			s_d.oe    = 1'b0;
		end else if (i2c_stop) begin
			s_d.st  = I2C_IDLE;
			s_d.drv = 1'b0;
			s_d.oe  = 1'b0;
		end
	end

	// State register, reset from either source
	always_ff @(posedge CLOCK) begin
		if (rst_any) begin
			s_q         <= '0;
			s_q.control <= CONTROL_RST;
			s_q.st      <= I2C_IDLE;
			s_q.pclk    <= PIXEL_INPUT_CLOCK;                   // No false edge on release
			s_q.nclk    <= PIXEL_INPUT_CLOCK_N;
			s_q.scl     <= 1'b1;
			s_q.sda     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// =========================================================================
	// Capture buffer
	picc_fifo #(
		.WIDTH(PIX_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (CLOCK),
		.rst      (rst_any),
		.in_valid (word_v & ~pd_active),
		.in_ready (fifo_ready),
		.in_data  (word),
		.out_valid(PIXEL_OUT_VALID),
		.out_ready(PIXEL_OUT_READY),
		.out_data (PIXEL_OUT_DATA)
	);

	// Registered outputs
	assign CAPTURE_STALL        = s_q.stall;
	assign MONITOR_SENSE_OUTPUT = s_q.mon;
	assign SERIAL_OUT_EN        = s_q.ser_en;
	assign SDA_OUT              = 1'b0;                         // Open drain, low only
	assign SDA_OE               = s_q.oe;

endmodule : picc_top
`default_nettype wire

//--- picc_ctrl_model.sv
// Graphics controller model: pixel clocks and pixel bus.
// Assumes send() is called just after a CLOCK rising edge.
`timescale 1ns/1ps
`default_nettype none
module picc_ctrl_model (
	// Clock and mode
	input	wire logic		clk,
	input	wire logic		wide,
	input	wire logic		dual,
	input	wire logic		rise,
	// Pixel side
	output	logic			clk_p,
	output	logic			clk_n,
	output	logic [23:0]	data
);
	// =======
	// Clock edges
	// Quiet lines before the first word
	initial begin
		clk_p = 1'h0;
		clk_n = 1'h0;
		data = 24'h000000;
	end
	// One edge on one line, each level held for hold cycles
	task automatic edge_on(input bit on_n, input bit up, input int hold);
		if (on_n) clk_n <= !up;
		else clk_p <= !up;
		repeat (hold) @(posedge clk);
		if (on_n) clk_n <= up;
		else clk_p <= up;
		repeat (hold) @(posedge clk);
	endtask : edge_on
	// One pixel word in the shape the mode needs
	task automatic send(input logic [23:0] w, input int hold);
		if (wide && dual) begin
			data <= w;
			clk_p <= !clk_p;
			repeat (hold + 1) @(posedge clk);
		end else if (wide) begin
			data <= w;
			edge_on(1'b0, rise, hold);
		end else begin
			data <= {~w[23:12], w[11:0]};
			edge_on(1'b0, dual ? 1'b0 : rise, hold);
			data <= {~w[11:0], w[23:12]};
			edge_on(!dual, dual ? 1'b1 : rise, hold);
		end
	endtask : send
endmodule : picc_ctrl_model
`default_nettype wire

//--- picc_sva.sv
// Port checks for the pixel input capture control block.
// Assumes binding to picc_top, one clock, resets RST and RESET_SELECT_N.
`timescale 1ns/1ps
`default_nettype none
module picc_sva (
	// Clock and resets
	input	wire logic		CLOCK,
	input	wire logic		RST,
	input	wire logic		RESET_SELECT_N,
	// Configuration
	input	wire logic		BUS_WIDTH_SELECT,
	input	wire logic		DUAL_LATCH_SELECT,
	input	wire logic		EDGE_SELECT,
	input	wire logic		DETECT_SOURCE,
	input	wire logic		SENSE_MODE,
	input	wire logic		POWER_DOWN_N,
	// Pixel path
	input	wire logic		PIXEL_INPUT_CLOCK,
	input	wire logic [picc_pkg::PIX_WIDTH-1:0]	PIXEL_DATA,
	input	wire logic		PIXEL_OUT_VALID,
	input	wire logic [picc_pkg::PIX_WIDTH-1:0]	PIXEL_OUT_DATA,
	// Detection and serial control
	input	wire logic		HOT_PLUG_INPUT,
	input	wire logic		RX_SENSE,
	input	wire logic		MONITOR_SENSE_OUTPUT,
	input	wire logic		SERIAL_OUT_EN
);
	import picc_pkg::*;
	// Selected detection source
	wire logic det = DETECT_SOURCE ? RX_SENSE : HOT_PLUG_INPUT;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST || !RESET_SELECT_N);
	// =======
	// Reset and power-down
	AST_RST_CLR: assert property (disable iff (1'b0)
		(RST || !RESET_SELECT_N) |=> !PIXEL_OUT_VALID && !SERIAL_OUT_EN && !MONITOR_SENSE_OUTPUT)
		else $error("outputs not cleared by reset");
	AST_PD_OFF: assert property (!POWER_DOWN_N |=> !SERIAL_OUT_EN)
		else $error("serial outputs on in power-down");
	AST_PD_DROP: assert property (!POWER_DOWN_N && !PIXEL_OUT_VALID |=> !PIXEL_OUT_VALID)
		else $error("word taken in power-down");
	// =======
	// Detection
	AST_DET_LEVEL: assert property (!SENSE_MODE |=> MONITOR_SENSE_OUTPUT == $past(det))
		else $error("sense output not the detect level");
	AST_DET_CHANGE: assert property (SENSE_MODE && !$past(RST || !RESET_SELECT_N) && det != $past(det) |=>
		MONITOR_SENSE_OUTPUT) else $error("change not flagged");
	// =======
	// Capture
	AST_FALL_CAP: assert property (BUS_WIDTH_SELECT && !DUAL_LATCH_SELECT && !EDGE_SELECT &&
		POWER_DOWN_N && $fell(PIXEL_INPUT_CLOCK) && !PIXEL_OUT_VALID
		|=> PIXEL_OUT_VALID && PIXEL_OUT_DATA == $past(PIXEL_DATA)) else $error("falling edge word lost");
	AST_RISE_CAP: assert property (BUS_WIDTH_SELECT && !DUAL_LATCH_SELECT && EDGE_SELECT &&
		POWER_DOWN_N && $rose(PIXEL_INPUT_CLOCK) && !PIXEL_OUT_VALID
		|=> PIXEL_OUT_VALID && PIXEL_OUT_DATA == $past(PIXEL_DATA)) else $error("rising edge word lost");
	AST_DUAL_CAP: assert property (BUS_WIDTH_SELECT && DUAL_LATCH_SELECT && POWER_DOWN_N &&
		$changed(PIXEL_INPUT_CLOCK) && !PIXEL_OUT_VALID |=> PIXEL_OUT_VALID)
		else $error("dual edge word lost");
	AST_HALF_PAIR: assert property (!BUS_WIDTH_SELECT && DUAL_LATCH_SELECT &&
		$rose(PIXEL_INPUT_CLOCK) && !PIXEL_OUT_VALID
		|=> !PIXEL_OUT_VALID || PIXEL_OUT_DATA[23:12] == $past(PIXEL_DATA[11:0]))
		else $error("second half misplaced");
	// Main scenarios reached
	COV_HALF: cover property (!BUS_WIDTH_SELECT && DUAL_LATCH_SELECT && $rose(PIXEL_INPUT_CLOCK));
	COV_PD: cover property (!POWER_DOWN_N ##1 POWER_DOWN_N);
	COV_FLAG: cover property (SENSE_MODE && MONITOR_SENSE_OUTPUT);
endmodule : picc_sva
bind picc_top picc_sva i_sva (
	.CLOCK(CLOCK), .RST(RST), .RESET_SELECT_N(RESET_SELECT_N),
	.BUS_WIDTH_SELECT(BUS_WIDTH_SELECT), .DUAL_LATCH_SELECT(DUAL_LATCH_SELECT),
	.EDGE_SELECT(EDGE_SELECT), .DETECT_SOURCE(DETECT_SOURCE), .SENSE_MODE(SENSE_MODE),
	.POWER_DOWN_N(POWER_DOWN_N), .PIXEL_INPUT_CLOCK(PIXEL_INPUT_CLOCK), .PIXEL_DATA(PIXEL_DATA),
	.PIXEL_OUT_VALID(PIXEL_OUT_VALID), .PIXEL_OUT_DATA(PIXEL_OUT_DATA),
	.HOT_PLUG_INPUT(HOT_PLUG_INPUT), .RX_SENSE(RX_SENSE),
	.MONITOR_SENSE_OUTPUT(MONITOR_SENSE_OUTPUT), .SERIAL_OUT_EN(SERIAL_OUT_EN));
`default_nettype wire

//--- picc_top_tb.sv
// Self-checking bench for the pixel input capture control block.
// Assumes the controller model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module picc_top_tb;
	import picc_pkg::*;
	// =======
	// Stimulus and observation
	logic			clk = 1'h0;
	logic			rst = 1'h1;
	logic			rs_n = 1'h1;
	logic			wide = 1'h1;
	logic			dual = 1'h0;
	logic			rise = 1'h0;
	logic			src = 1'h0;
	logic			smode = 1'h0;
	logic			pd_n = 1'h1;
	logic			rdy = 1'h0;
	logic			pop_en = 1'h1;
	logic			hp = 1'h0;
	logic			rx = 1'h0;
	logic			ckp, ckn, ov, stall, mon, sen, sda_oe;
	logic			scl = 1'h1;
	logic			sda = 1'h1;
	logic			sda_out;
	logic [7:0]		rb;
	// Open-drain line: the block can only pull it low
	wire logic		sda_w = sda & (sda_oe ? sda_out : 1'h1);
	logic [23:0]	pd, od;
	logic [23:0]	exp_q[$];
	logic [31:0]	rs = 32'h00000062;
	logic [2:0]		modes[6] = '{3'h4, 3'h5, 3'h6, 3'h2, 3'h0, 3'h1};
	int				error_cnt = 0;
	int				compares = 0;
	int				cyc = 0;
	always #5 clk = ~clk;
	picc_top i_dut (
		.CLOCK(clk), .RST(rst), .RESET_SELECT_N(rs_n),
		.BUS_WIDTH_SELECT(wide), .DUAL_LATCH_SELECT(dual), .EDGE_SELECT(rise),
		.DETECT_SOURCE(src), .SENSE_MODE(smode), .POWER_DOWN_N(pd_n),
		.PIXEL_INPUT_CLOCK(ckp), .PIXEL_INPUT_CLOCK_N(ckn), .PIXEL_DATA(pd),
		.PIXEL_OUT_VALID(ov), .PIXEL_OUT_READY(rdy), .PIXEL_OUT_DATA(od), .CAPTURE_STALL(stall),
		.HOT_PLUG_INPUT(hp), .RX_SENSE(rx), .MONITOR_SENSE_OUTPUT(mon), .SERIAL_OUT_EN(sen),
		.SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe));
	picc_ctrl_model i_ctrl (.clk(clk), .wide(wide), .dual(dual), .rise(rise),
		.clk_p(ckp), .clk_n(ckn), .data(pd));
	// =======
	// Helpers
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	task automatic chk(input logic [23:0] got, input logic [23:0] want, input string what);
		compares++;
		if (got !== want) begin
			error_cnt++;
			$display("BAD %0t %s: got %h want %h", $time, what, got, want);
		end
	endtask : chk
	task automatic final_report();
		$display("Counts: %0d mismatches, %0d compares", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// Two-wire host at 100 kHz: 1000-cycle bit, sampled late in the high phase
	task automatic i2c_bit(input logic b, output logic r);
		sda <= b;
		repeat (250) @(posedge clk);
		scl <= 1'h1;
		repeat (500) @(posedge clk);
		r = sda_w;
		scl <= 1'h0;
		repeat (250) @(posedge clk);
	endtask : i2c_bit
	// Start (data falls, clock high) or stop (data rises, clock high)
	task automatic i2c_cond(input logic stop);
		sda <= !stop;
		repeat (250) @(posedge clk);
		scl <= 1'h1;
		repeat (250) @(posedge clk);
		sda <= stop;
		repeat (250) @(posedge clk);
		if (!stop) scl <= 1'h0;
		repeat (250) @(posedge clk);
	endtask : i2c_cond
	// Byte MSB first, then the ninth bit released and compared
	task automatic i2c_byte(input logic [7:0] w, input logic ack, output logic [7:0] got);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(w[i], a);
			got[i] = a;
		end
		i2c_bit(1'h1, a);
		chk(24'(a), 24'(ack), "acknowledge");
	endtask : i2c_byte
	// Send a word; the reference keeps it if powered up and the buffer has room
	task automatic put(input logic [23:0] w);
		if (pd_n && exp_q.size() < FIFO_DEPTH) exp_q.push_back(w);
		i_ctrl.send(w, 1 + int'(rnd() % 3));
	endtask : put
	task automatic drain();
		int n = 0;
		pop_en <= 1'h1;
		while (exp_q.size() != 0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		chk(24'(exp_q.size()), 24'h0, "words missing");
	endtask : drain
	// Reference buffer: each accepted word must be the oldest sent
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rdy <= pop_en & (cyc[0] | rs[7]);
		if (!rst && rs_n && ov === 1'h1 && rdy === 1'h1) begin
			if (exp_q.size() == 0) chk(24'h1, 24'h0, "unexpected word");
			else chk(od, exp_q.pop_front(), "word");
		end
		if (cyc == 90000) begin
			error_cnt++;
			final_report();
		end
	end
	// =======
	// Scenarios
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0; // Pixel clock already steady
		@(negedge clk);
		chk(24'(ov), 24'h0, "valid after reset");
		@(posedge clk);
		// Every latching mode carries six words
		foreach (modes[i]) begin
			{wide, dual, rise} <= modes[i];
			@(posedge clk);
			repeat (6) put(rnd());
			drain();
		end
		// Full buffer refuses words and stalls
		{wide, dual, rise} <= 3'h4;
		pop_en <= 1'h0;
		@(posedge clk);
		repeat (10) put(rnd());
		@(negedge clk);
		chk(24'(stall), 24'h1, "stall");
		@(posedge clk);
		drain();
		// Power-down drops words and turns the serial side off
		@(negedge clk);
		chk(24'(sen), 24'h1, "serial off");
		@(posedge clk);
		pd_n <= 1'h0;
		@(posedge clk);
		repeat (2) put(rnd());
		@(negedge clk);
		chk(24'(sen), 24'h0, "serial on in power-down");
		chk(24'(ov), 24'h0, "word kept in power-down");
		@(posedge clk);
		pd_n <= 1'h1;
		drain();
		// Detection level from either source
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{src, hp, rx} <= 3'(rnd());
			repeat (3) @(posedge clk);
			@(negedge clk);
			chk(24'(mon), 24'(src ? rx : hp), "detect level");
		end
		// Reset pin mid-stream, then the sticky change flag
		@(posedge clk);
		pop_en <= 1'h0;
		repeat (3) put(rnd());
		{rs_n, src, hp, smode} <= 4'h1;
		repeat (1000) @(posedge clk); // Low for 10 us
		exp_q.delete();
		rs_n <= 1'h1;
		pop_en <= 1'h1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(24'(ov), 24'h0, "buffer after reset");
		chk(24'(mon), 24'h0, "flag without change");
		@(posedge clk);
		hp <= 1'h1;
		repeat (3) @(posedge clk);
		hp <= 1'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(24'(mon), 24'h1, "change flag lost");
		chk(24'(sda_oe), 24'h0, "bus driven while idle");
		// Programming port: clear the change flag, set soft power-down
		@(posedge clk);
		i2c_cond(1'h0);
		i2c_byte({I2C_DEV_ADDR, 1'h0}, 1'h0, rb);
		i2c_byte(REG_STATUS, 1'h0, rb);
		i2c_byte(8'(1 << ST_CHANGE), 1'h0, rb);
		i2c_byte(8'(1 << CT_SOFT_PD), 1'h0, rb);
		i2c_cond(1'h1);
		@(negedge clk);
		chk(24'(mon), 24'h0, "change flag not cleared");
		chk(24'(sen), 24'h0, "soft power-down ignored");
		// Point at status, restart and read it back
		@(posedge clk);
		i2c_cond(1'h0);
		i2c_byte({I2C_DEV_ADDR, 1'h0}, 1'h0, rb);
		i2c_byte(REG_STATUS, 1'h0, rb);
		i2c_cond(1'h0);
		i2c_byte({I2C_DEV_ADDR, 1'h1}, 1'h0, rb);
		i2c_byte(8'hFF, 1'h1, rb);
		i2c_cond(1'h1);
		chk(24'(rb), 24'(1 << ST_PWR_DOWN), "status read");
		final_report();
	end
endmodule : picc_top_tb
`default_nettype wire
